// ---- design/bpc_pkg.sv ----
// Constants, types and timing counts for the buck phase, clock and load-current measurement control.
// Assumes a 20 MHz system clock and 9-bit current codes from the phase current sensors.
package bpc_pkg;

	// System clock rate
	localparam int CLK_MHZ = 20;

	// Measurement sequence length, longest time rounded down
	localparam int MEAS_TIME_US = 50;
	localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
	localparam logic [9:0] MEAS_LAST = 10'(MEAS_CYCLES - 1);
	localparam logic [9:0] MEAS_CNT_ZERO = 10'h000;

	// Current codes, 20 mA per count, 511 counts is 10.22 A
	localparam int RES_W = 9;
	localparam int LSB_MA = 20;
	localparam int PWM_ENTRY_MA = 600;
	localparam int PHASE_ADD_MA = 2400;
	localparam int PHASE_SHED_MA = 1800;
	localparam logic [8:0] PWM_CODE = 9'(PWM_ENTRY_MA / LSB_MA);
	localparam logic [9:0] PWM_SUM_CODE = 10'(PWM_ENTRY_MA / LSB_MA);
	localparam logic [9:0] ADD_CODE = 10'(PHASE_ADD_MA / LSB_MA);
	localparam logic [9:0] SHED_CODE = 10'(PHASE_SHED_MA / LSB_MA);
	localparam logic [9:0] RESULT_MAX = 10'h1ff;

	// Switching period and half-period offset of the second phase
	localparam int SW_FREQ_KHZ = 2000;
	localparam int SW_PERIOD = CLK_MHZ * 1000 / SW_FREQ_KHZ;
	localparam logic [3:0] SW_LAST = 4'(SW_PERIOD - 1);
	localparam logic [3:0] SW_HALF = 4'(SW_PERIOD / 2);
	localparam logic [3:0] SW_ZERO = 4'h0;

	// External clock nominal frequency, code 0 is 1 MHz, capped at 24 MHz
	localparam logic [4:0] EXT_BASE_MHZ = 5'h01;
	localparam logic [4:0] EXT_MAX_MHZ = 5'h18;
	localparam logic [4:0] EXT_MAX_CODE = 5'h17;
	localparam logic [19:0] TOL_LO_PCT = 20'h00046;
	localparam logic [19:0] TOL_HI_PCT = 20'h0006e;
	localparam logic [19:0] RATIO_LIMIT = 20'(CLK_MHZ * 100);
	localparam logic [7:0] PER_MAX = 8'hff;
	localparam logic [7:0] PER_START = 8'h01;
	localparam logic [1:0] LOCK_PERIODS = 2'h2;

	// Spread-spectrum frequency trim ramp
	localparam logic [4:0] SS_STEP_LAST = 5'h13;
	localparam logic [3:0] SS_CENTRE = 4'h8;
	localparam logic [3:0] SS_TOP = 4'hf;
	localparam logic [3:0] SS_BOTTOM = 4'h0;

	// Device operating state
	typedef enum logic [1:0]
	{
		PWR_INIT = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_ACTIVE = 2'b10
	} bpc_pwr_e;

endpackage : bpc_pkg

// ---- design/bpc_meas_seq.sv ----
// Load-current measurement sequencer: timed window, result capture and done pulse.
// Assumes start is a one-cycle pulse on clk and current codes are synchronous to clk.
`timescale 1ns/1ns
module bpc_meas_seq
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic start,
	input wire logic select,
	input wire logic dual,
	input wire logic [8:0] masterCurrent,
	input wire logic [8:0] slaveCurrent,
	output logic busy,
	output logic sel,
	output logic done,
	output logic [8:0] result
);

	typedef struct packed
	{
		logic busy;
		logic sel;
		logic done;
		logic [9:0] cnt;
		logic [8:0] result;
	} bpc_meas_s;

	bpc_meas_s st;
	bpc_meas_s next_st;
	logic [9:0] sum;
	logic [8:0] sumSat;

	// Total of both phases, saturated at the top code
	assign sum = {1'b0, masterCurrent} + {1'b0, slaveCurrent};
	assign sumSat = (sum > bpc_pkg::RESULT_MAX) ? bpc_pkg::RESULT_MAX[8:0] : sum[8:0];

	// Sequence control
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (start)
		begin
			next_st.busy = 1'b1;
			next_st.sel = select;
			next_st.cnt = bpc_pkg::MEAS_CNT_ZERO;
		end
		else if (st.busy)
		begin
			if (st.cnt == bpc_pkg::MEAS_LAST)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				if (dual)
					next_st.result = sumSat;
				else
					next_st.result = st.sel ? slaveCurrent : masterCurrent;
			end
			else
				next_st.cnt = st.cnt + 10'h001;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st <= '0;
		else if (clkEn)
			st <= next_st;
	end

	assign busy = st.busy;
	assign sel = st.sel;
	assign done = st.done;
	assign result = st.result;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_start_busy;
		start && clkEn |=> busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("measurement did not start");

	property p_dual_sum;
		done && $past(clkEn) && $past(dual) |-> result == $past(sumSat);
	endproperty
	a_dual_sum: assert property (p_dual_sum) else $error("dual result is not the phase total");

	property p_result_hold;
		!done |-> $stable(result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed outside completion");

endmodule : bpc_meas_seq

// ---- design/bpc_ctrl.sv ----
// Buck pair digital control: phase count, PWM/PFM choice, measurement, spread spectrum, sync clock.
// Assumes control bits come from a register file on clk; syncClockInput is an asynchronous pin.
//
// Contract
// - Two phases run 180 degrees apart
// - Forced multiphase runs both phases, forced PWM
// - Unforced: second phase added or shed by load
// - Auto mode: PWM from about 600 mA, else PFM
// - Only dual-phase or two single-phase arrangements
// - Dual-phase ignores slave settings, listed exceptions kept
// - Select bit; any selection write starts measurement
// - Measurement forces PWM, ends within 50 us
// - Completion sets done flag, maskable
// - Nine-bit result split low byte, bit eight
// - One count is 20 mA, top 10.22 A
// - Dual-phase result is master plus slave
// - Spread spectrum enabled only with PLL off
// - Spread spectrum varies frequency around centre
// - Five-bit field picks 1 to 24 MHz
// - External clock valid within -30%/+10%
// - PLL on: auto switch, appear/disappear interrupt
// - Sync-clock interrupt has its own mask
// - Missing expected clock raises sync interrupt
// - After initialisation device enters standby
`timescale 1ns/1ns
module bpc_ctrl
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic otpLoadDone,
	input wire logic buckEnable,
	input wire logic dualPhaseCfg,
	input wire logic forceMultiphaseBit,
	input wire logic masterFpwm,
	input wire logic slaveFpwm,
	input wire logic [8:0] masterCurrent,
	input wire logic [8:0] slaveCurrent,
	input wire logic [7:0] masterVoutReg,
	input wire logic [7:0] slaveBuckVoltageReg,
	input wire logic [7:0] masterDelayReg,
	input wire logic [7:0] slaveBuckDelayReg,
	input wire logic slaveDischargeEnable,
	input wire logic [2:0] slaveCurrentLimitField,
	input wire logic slaveCurrentLimitEvent,
	input wire logic slaveOtherIntEvent,
	input wire logic measSelectWrite,
	input wire logic measSelect,
	input wire logic measurementDoneMask,
	input wire logic syncClockMask,
	input wire logic measFlagClear,
	input wire logic syncFlagClear,
	input wire logic spreadSpectrumEnable,
	input wire logic pllEnable,
	input wire logic [4:0] externalClockFreqSelect,
	input wire logic syncClockInput,
	output logic inStandby,
	output logic inActive,
	output logic buck0Pwm,
	output logic buck1Pwm,
	output logic secondPhaseOn,
	output logic phaseTick0,
	output logic phaseTick1,
	output logic extClockValid,
	output logic extClockSelected,
	output logic spreadActive,
	output logic [3:0] spreadTrim,
	output logic measBusy,
	output logic measurementDoneFlag,
	output logic syncClockFlag,
	output logic irqOut,
	output logic [7:0] loadCurrentLow,
	output logic loadCurrentHigh,
	output logic [7:0] buck1VoutEff,
	output logic [7:0] buck1DelayEff,
	output logic slaveDischargeOut,
	output logic [2:0] slaveIlimOut,
	output logic slaveCurrentLimitFlag,
	output logic slaveOtherIntOut
);

	typedef struct packed
	{
		bpc_pkg::bpc_pwr_e pwr;
		logic buckEnPrev;
		logic syncA;
		logic syncB;
		logic syncPrev;
		logic [7:0] perCnt;
		logic [1:0] goodCnt;
		logic extValid;
		logic extSel;
		logic dualActive;
		logic pwm0;
		logic pwm1;
		logic [3:0] swCnt;
		logic tick0;
		logic tick1;
		logic ssOn;
		logic [4:0] ssCnt;
		logic ssUp;
		logic [3:0] ssTrim;
		logic measFlag;
		logic syncFlag;
		logic irq;
		logic [7:0] vout1;
		logic [7:0] delay1;
		logic rdis1;
		logic [2:0] slave_current_limit_field;
		logic ilimFlag1;
		logic otherInt1;
		logic [9:0] busyCnt;
	} bpc_ctrl_s;

	bpc_ctrl_s st;
	bpc_ctrl_s next_st;
	logic measBusyInt;
	logic measSel;
	logic measDone;
	logic [8:0] measResult;
	logic [9:0] totalCurrent;
	logic [4:0] nomMhz;
	logic [12:0] span;
	logic periodOk;
	logic syncRise;
	logic buckEnRise;
	logic buckEnFall;
	logic missingExt;
	logic syncEvent;
	logic [9:0] busyCount;

	bpc_meas_seq u_meas
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.start(measSelectWrite),
		.select(measSelect),
		.dual(dualPhaseCfg),
		.masterCurrent(masterCurrent),
		.slaveCurrent(slaveCurrent),
		.busy(measBusyInt),
		.sel(measSel),
		.done(measDone),
		.result(measResult)
	);

	// Phase total and nominal external frequency
	assign totalCurrent = {1'b0, masterCurrent} + {1'b0, slaveCurrent};
	assign nomMhz = (externalClockFreqSelect > bpc_pkg::EXT_MAX_CODE) ? bpc_pkg::EXT_MAX_MHZ
		: externalClockFreqSelect + bpc_pkg::EXT_BASE_MHZ;
	assign span = 13'(st.perCnt) * 13'(nomMhz);
	assign periodOk = (20'(span) * bpc_pkg::TOL_LO_PCT <= bpc_pkg::RATIO_LIMIT)
		&& (20'(span) * bpc_pkg::TOL_HI_PCT >= bpc_pkg::RATIO_LIMIT);
	assign syncRise = st.syncB && !st.syncPrev;
	assign buckEnRise = buckEnable && !st.buckEnPrev;
	assign buckEnFall = !buckEnable && st.buckEnPrev;

	// Next-state logic
	always_comb
	begin
		next_st = st;
		missingExt = 1'b0;
		syncEvent = 1'b0;
		next_st.buckEnPrev = buckEnable;

		case (st.pwr)
			bpc_pkg::PWR_INIT:
			begin
				if (otpLoadDone)
				begin
					next_st.pwr = bpc_pkg::PWR_STANDBY;
					missingExt = pllEnable && !st.extValid;
				end
			end
			bpc_pkg::PWR_STANDBY:
			begin
				if (buckEnRise)
				begin
					next_st.pwr = bpc_pkg::PWR_ACTIVE;
					missingExt = pllEnable && !st.extValid;
				end
			end
			bpc_pkg::PWR_ACTIVE:
			begin
				if (buckEnFall)
					next_st.pwr = bpc_pkg::PWR_STANDBY;
			end
			default:
				next_st.pwr = bpc_pkg::PWR_INIT;
		endcase

		// Two-flop synchroniser and period measurement
		next_st.syncA = syncClockInput;
		next_st.syncB = st.syncA;
		next_st.syncPrev = st.syncB;
		if (syncRise)
		begin
			next_st.perCnt = bpc_pkg::PER_START;
			if (periodOk)
			begin
				if (st.goodCnt != bpc_pkg::LOCK_PERIODS)
					next_st.goodCnt = st.goodCnt + 2'h1;
				else
					next_st.extValid = 1'b1;
			end
			else
			begin
				next_st.goodCnt = 2'h0;
				next_st.extValid = 1'b0;
			end
		end
		else if (st.perCnt != bpc_pkg::PER_MAX)
			next_st.perCnt = st.perCnt + 8'h01;
		else
		begin
			next_st.goodCnt = 2'h0;
			next_st.extValid = 1'b0;
		end

		next_st.extSel = pllEnable && next_st.extValid && (st.pwr != bpc_pkg::PWR_INIT);
		syncEvent = pllEnable && (st.pwr != bpc_pkg::PWR_INIT) && (next_st.extValid != st.extValid);

		// automatic phase add and shed with hysteresis
		if (!dualPhaseCfg)
			next_st.dualActive = 1'b0;
		else if (forceMultiphaseBit || (measBusyInt && !measSelectWrite))
			next_st.dualActive = 1'b1;
		else if (totalCurrent >= bpc_pkg::ADD_CODE)
			next_st.dualActive = 1'b1;
		else if (totalCurrent < bpc_pkg::SHED_CODE)
			next_st.dualActive = 1'b0;

		// arrangement selects master-led or independent modes
		if (dualPhaseCfg)
		begin
			// auto PWM/PFM on total load; forced during measurement
			next_st.pwm0 = forceMultiphaseBit || masterFpwm || measBusyInt
				|| (totalCurrent >= bpc_pkg::PWM_SUM_CODE);
			// slave follows master, its own mode bit ignored
			next_st.pwm1 = next_st.pwm0;
		end
		else
		begin
			next_st.pwm0 = masterFpwm || (measBusyInt && !measSel) || (masterCurrent >= bpc_pkg::PWM_CODE);
			next_st.pwm1 = slaveFpwm || (measBusyInt && measSel) || (slaveCurrent >= bpc_pkg::PWM_CODE);
		end

		// second phase fires half a period after the first
		if (st.swCnt == bpc_pkg::SW_LAST)
			next_st.swCnt = bpc_pkg::SW_ZERO;
		else
			next_st.swCnt = st.swCnt + 4'h1;
		next_st.tick0 = next_st.swCnt == bpc_pkg::SW_ZERO;
		next_st.tick1 = st.dualActive && (next_st.swCnt == bpc_pkg::SW_HALF); // Settled phase count only

		// spread spectrum only on internal oscillator
		next_st.ssOn = spreadSpectrumEnable && !pllEnable;
		if (!next_st.ssOn)
		begin
			next_st.ssCnt = 5'h00;
			next_st.ssUp = 1'b1;
			next_st.ssTrim = bpc_pkg::SS_CENTRE;
		end
		else if (st.ssCnt == bpc_pkg::SS_STEP_LAST)
		begin
			next_st.ssCnt = 5'h00;
			if (st.ssUp && st.ssTrim == bpc_pkg::SS_TOP)
			begin
				next_st.ssUp = 1'b0;
				next_st.ssTrim = st.ssTrim - 4'h1;
			end
			else if (!st.ssUp && st.ssTrim == bpc_pkg::SS_BOTTOM)
			begin
				next_st.ssUp = 1'b1;
				next_st.ssTrim = st.ssTrim + 4'h1;
			end
			else
				next_st.ssTrim = st.ssUp ? st.ssTrim + 4'h1 : st.ssTrim - 4'h1;
		end
		else
			next_st.ssCnt = st.ssCnt + 5'h01;

		// done flag, set wins over clear
		if (measDone)
			next_st.measFlag = 1'b1;
		else if (measFlagClear)
			next_st.measFlag = 1'b0;
		if (syncEvent || missingExt)
			next_st.syncFlag = 1'b1;
		else if (syncFlagClear)
			next_st.syncFlag = 1'b0;
		next_st.irq = (st.measFlag && !measurementDoneMask) || (st.syncFlag && !syncClockMask);

		// slave register takeover in dual-phase, exceptions pass through
		next_st.vout1 = dualPhaseCfg ? masterVoutReg : slaveBuckVoltageReg;
		next_st.delay1 = dualPhaseCfg ? masterDelayReg : slaveBuckDelayReg;
		next_st.rdis1 = slaveDischargeEnable;
		next_st.slave_current_limit_field = slaveCurrentLimitField;
		next_st.ilimFlag1 = slaveCurrentLimitEvent;
		next_st.otherInt1 = slaveOtherIntEvent && !dualPhaseCfg;

		// busy length count for the window check
		if (measSelectWrite || !measBusyInt)
			next_st.busyCnt = 10'h000;
		else
			next_st.busyCnt = st.busyCnt + 10'h001;
	end

	// State register with clock enable
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.pwr <= bpc_pkg::PWR_INIT;
			st.ssUp <= 1'b1;
			st.ssTrim <= bpc_pkg::SS_CENTRE;
		end
		else if (clkEn)
			st <= next_st;
	end

	// Measurement window watch for checking
	assign busyCount = st.busyCnt;

	// Outputs
	assign inStandby = st.pwr == bpc_pkg::PWR_STANDBY;
	assign inActive = st.pwr == bpc_pkg::PWR_ACTIVE;
	assign buck0Pwm = st.pwm0;
	assign buck1Pwm = st.pwm1;
	assign secondPhaseOn = st.dualActive;
	assign phaseTick0 = st.tick0;
	assign phaseTick1 = st.tick1;
	assign extClockValid = st.extValid;
	assign extClockSelected = st.extSel;
	assign spreadActive = st.ssOn;
	assign spreadTrim = st.ssTrim;
	assign measBusy = measBusyInt;
	assign measurementDoneFlag = st.measFlag;
	assign syncClockFlag = st.syncFlag;
	assign irqOut = st.irq;
	// result split, 20 mA per count
	assign loadCurrentLow = measResult[7:0];
	assign loadCurrentHigh = measResult[8];
	assign buck1VoutEff = st.vout1;
	assign buck1DelayEff = st.delay1;
	assign slaveDischargeOut = st.rdis1;
	assign slaveIlimOut = st.slave_current_limit_field;
	assign slaveCurrentLimitFlag = st.ilimFlag1;
	assign slaveOtherIntOut = st.otherInt1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_tick0_run;
		phaseTick0 && secondPhaseOn && clkEn ##1 (clkEn && secondPhaseOn)[*4];
	endsequence

	property p_phase_180;
		s_tick0_run |=> phaseTick1;
	endproperty
	a_phase_180: assert property (p_phase_180) else $error("second phase not half a period later");

	property p_forced_mp;
		clkEn && dualPhaseCfg && forceMultiphaseBit |=> buck0Pwm && buck1Pwm && secondPhaseOn;
	endproperty
	a_forced_mp: assert property (p_forced_mp) else $error("forced multiphase not both phases in PWM");

	property p_pfm_light;
		clkEn && !dualPhaseCfg && !slaveFpwm && !measBusy && !measSelectWrite
			&& slaveCurrent < bpc_pkg::PWM_CODE |=> !buck1Pwm;
	endproperty
	a_pfm_light: assert property (p_pfm_light) else $error("slave buck in PWM at light load");

	property p_slave_ignored;
		clkEn && dualPhaseCfg |=> buck1VoutEff == $past(masterVoutReg) && !slaveOtherIntOut;
	endproperty
	a_slave_ignored: assert property (p_slave_ignored) else $error("slave setting used in dual-phase");

	property p_meas_len;
		busyCount <= 10'(bpc_pkg::MEAS_CYCLES);
	endproperty
	a_meas_len: assert property (p_meas_len) else $error("measurement ran past its window");

	property p_meas_flag;
		clkEn && measDone |=> measurementDoneFlag;
	endproperty
	a_meas_flag: assert property (p_meas_flag) else $error("done flag not set on completion");

	property p_flag_sticky;
		clkEn && measurementDoneFlag && !measFlagClear |=> measurementDoneFlag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("done flag dropped without clear");

	property p_spread_pll;
		clkEn && pllEnable |=> !spreadActive && spreadTrim == bpc_pkg::SS_CENTRE;
	endproperty
	a_spread_pll: assert property (p_spread_pll) else $error("spread spectrum active with PLL on");

	property p_rc_when_pll_off;
		clkEn && !pllEnable |=> !extClockSelected;
	endproperty
	a_rc_when_pll_off: assert property (p_rc_when_pll_off) else $error("external clock used with PLL off");

	property p_sync_irq;
		clkEn && syncClockFlag && !syncClockMask |=> irqOut;
	endproperty
	a_sync_irq: assert property (p_sync_irq) else $error("unmasked sync flag gave no interrupt");

endmodule : bpc_ctrl

// ---- dv/bpc_sync_src.sv ----
// Partner model: external sync clock source driving the sync pin.
// Assumes the bench raises run inside a frame; the pin rests low between frames.
`timescale 1ns/1ns
module bpc_sync_src
#(
	parameter int HALF_NS = 200
)
(
	input wire logic run,
	output logic syncOut
);
	// source held at a fixed rate, the bench picks the nominal code
	// Toggle while running, stand still low otherwise
	initial
	begin
		syncOut = 1'b0;
		#37;
		forever
		begin
			if (run)
			begin
				#(HALF_NS);
				syncOut = run ? ~syncOut : 1'b0;
			end
			else
			begin
				syncOut = 1'b0;
				@(posedge run);
			end
		end
	end
endmodule : bpc_sync_src

// ---- dv/tb_bpc_ctrl.sv ----
// Self-checking bench for the buck phase, sync clock and measurement control.
// Assumes the sync source partner model and a 20 MHz clock.
`timescale 1ns/1ns
module tb_bpc_ctrl;
	logic clk, sys_rst, clkEn, otpLoadDone, buckEnable, dualPhaseCfg, forceMultiphaseBit, masterFpwm, slaveFpwm;
	logic [8:0] masterCurrent, slaveCurrent, v, a, b;
	logic [7:0] masterVoutReg, slaveBuckVoltageReg, masterDelayReg, slaveBuckDelayReg;
	logic slaveDischargeEnable, slaveCurrentLimitEvent, slaveOtherIntEvent, measSelectWrite, measSelect;
	logic [2:0] slaveCurrentLimitField, slaveIlimOut;
	logic measurementDoneMask, syncClockMask, measFlagClear, syncFlagClear, spreadSpectrumEnable, pllEnable;
	logic [4:0] externalClockFreqSelect;
	logic syncClockInput, syncRun, wasBusy;
	logic inStandby, inActive, buck0Pwm, buck1Pwm, secondPhaseOn, phaseTick0, phaseTick1, extClockValid;
	logic extClockSelected, spreadActive, measBusy, measurementDoneFlag, syncClockFlag, irqOut, loadCurrentHigh;
	logic [3:0] spreadTrim, t;
	logic [7:0] loadCurrentLow, buck1VoutEff, buck1DelayEff;
	logic slaveDischargeOut, slaveCurrentLimitFlag, slaveOtherIntOut;
	logic [8:0] expQ[$];
	int nErrors, checkCount, n, k;

	bpc_ctrl dut_u
	(
		.clk, .sys_rst, .clkEn, .otpLoadDone, .buckEnable, .dualPhaseCfg, .forceMultiphaseBit, .masterFpwm,
		.slaveFpwm, .masterCurrent, .slaveCurrent, .masterVoutReg, .slaveBuckVoltageReg, .masterDelayReg,
		.slaveBuckDelayReg, .slaveDischargeEnable, .slaveCurrentLimitField, .slaveCurrentLimitEvent,
		.slaveOtherIntEvent, .measSelectWrite, .measSelect, .measurementDoneMask, .syncClockMask, .measFlagClear,
		.syncFlagClear, .spreadSpectrumEnable, .pllEnable, .externalClockFreqSelect, .syncClockInput, .inStandby,
		.inActive, .buck0Pwm, .buck1Pwm, .secondPhaseOn, .phaseTick0, .phaseTick1, .extClockValid,
		.extClockSelected, .spreadActive, .spreadTrim, .measBusy, .measurementDoneFlag, .syncClockFlag, .irqOut,
		.loadCurrentLow, .loadCurrentHigh, .buck1VoutEff, .buck1DelayEff, .slaveDischargeOut, .slaveIlimOut,
		.slaveCurrentLimitFlag, .slaveOtherIntOut
	);

	bpc_sync_src sync_u
	(
		.run(syncRun),
		.syncOut(syncClockInput)
	);

	// Free-running system clock
	always #25 clk = ~clk;

	task automatic bad(input string msg);
		nErrors++;
		$display("BAD %0t %s", $time, msg);
	endtask : bad

	task automatic chkBit(input logic got, input logic exp, input string msg);
		checkCount++;
		if (got !== exp)
			bad(msg);
	endtask : chkBit

	task automatic chkVal(input logic [8:0] got, input logic [8:0] exp, input string msg);
		checkCount++;
		if (got !== exp)
			bad(msg);
	endtask : chkVal

	task automatic cmpRes(input logic [8:0] got);
		checkCount++;
		if (expQ.size() == 0)
			bad("unexpected result");
		else if (got !== expQ.pop_front())
			bad("measurement result");
	endtask : cmpRes

	// Wait n edges, then look where outputs are settled
	task automatic settle(input int cnt);
		repeat (cnt) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic clr();
		@(posedge clk);
		measFlagClear <= 1'b1;
		syncFlagClear <= 1'b1;
		@(posedge clk);
		measFlagClear <= 1'b0;
		syncFlagClear <= 1'b0;
		settle(2);
		chkBit(measurementDoneFlag | syncClockFlag, 1'b0, "flags clear");
	endtask : clr

	task automatic meas(input logic dl, input logic sel, input logic [8:0] mc, input logic [8:0] sc,
		input logic mask, input logic [8:0] exp);
		int i;
		@(posedge clk);
		dualPhaseCfg <= dl;
		masterCurrent <= mc;
		slaveCurrent <= sc;
		measurementDoneMask <= mask;
		measSelect <= sel;
		measSelectWrite <= 1'b1;
		expQ.push_back(exp);
		@(posedge clk);
		measSelectWrite <= 1'b0;
		for (i = 1; i < 1100; i++)
		begin
			settle(1);
			if (i == 2)
				chkBit(sel ? buck1Pwm : buck0Pwm, 1'b1, "pwm forced");
			if (measBusy === 1'b0)
				break;
		end
		chkBit(i <= bpc_pkg::MEAS_CYCLES, 1'b1, "measurement length");
		settle(1);
		chkBit(measurementDoneFlag, 1'b1, "done flag");
		settle(1);
		chkBit(irqOut, !mask, "done irq");
	endtask : meas

	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// Result monitor, takes the oldest note when busy drops
	always @(negedge clk)
	begin
		if (wasBusy === 1'b1 && measBusy === 1'b0)
			cmpRes({loadCurrentHigh, loadCurrentLow});
		wasBusy = measBusy;
	end

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		bad("watchdog expired");
		conclude();
	end

	// Main sequence
	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		clkEn = 1'b1;
		{otpLoadDone, buckEnable, dualPhaseCfg, forceMultiphaseBit, masterFpwm, slaveFpwm, masterCurrent,
			slaveCurrent, masterVoutReg, slaveBuckVoltageReg, masterDelayReg, slaveBuckDelayReg,
			slaveDischargeEnable, slaveCurrentLimitField, slaveCurrentLimitEvent, slaveOtherIntEvent,
			measSelectWrite, measSelect, measurementDoneMask, syncClockMask, measFlagClear, syncFlagClear,
			spreadSpectrumEnable, syncRun} = '0;
		pllEnable = 1'b1;
		externalClockFreqSelect = 5'h02;
		nErrors = 0;
		checkCount = 0;
		void'($urandom(735));
		settle(1);
		chkBit(inStandby | irqOut | measBusy, 1'b0, "reset outputs");
		chkVal(9'(spreadTrim), 9'h008, "reset trim");
		@(posedge clk);
		sys_rst <= 1'b0;
		// no host access until the device reports standby
		@(posedge clk);
		otpLoadDone <= 1'b1;
		@(posedge clk);
		otpLoadDone <= 1'b0;
		settle(3);
		chkBit(inStandby, 1'b1, "standby entry");
		chkBit(syncClockFlag, 1'b1, "missing clock at start");
		clr();
		$display("power-up test done");
		v = 9'($urandom_range(29, 1));
		meas(1'b0, 1'b1, 9'h000, v, 1'b0, v);
		@(posedge clk);
		slaveCurrent <= v + 9'h064;
		settle(3);
		chkVal({loadCurrentHigh, loadCurrentLow}, v, "result held");
		clr();
		a = 9'($urandom_range(255, 0));
		b = 9'($urandom_range(255, 0));
		meas(1'b1, 1'b0, a, b, 1'b1, a + b);
		chkBit(measurementDoneFlag, 1'b1, "flag under mask");
		clr();
		a = 9'($urandom_range(511, 300));
		meas(1'b1, 1'b0, a, a, 1'b0, 9'h1ff);
		clr();
		$display("measurement test done");
		@(posedge clk);
		pllEnable <= 1'b0;
		spreadSpectrumEnable <= 1'b1;
		settle(3);
		chkBit(spreadActive, 1'b1, "spread on");
		t = spreadTrim;
		settle(25);
		chkBit(spreadTrim !== t, 1'b1, "trim moves");
		@(posedge clk);
		pllEnable <= 1'b1;
		settle(3);
		chkBit(spreadActive, 1'b0, "spread off with pll");
		chkVal(9'(spreadTrim), 9'h008, "trim centre");
		clr();
		$display("spread test done");
		@(posedge clk);
		syncClockMask <= 1'b1;
		syncRun <= 1'b1;
		for (n = 0; n < 100 && extClockValid !== 1'b1; n++)
			settle(1);
		settle(2);
		chkBit(extClockSelected, 1'b1, "switch to external");
		chkBit(syncClockFlag, 1'b1, "appear flag");
		chkBit(irqOut, 1'b0, "sync masked");
		@(posedge clk);
		syncClockMask <= 1'b0;
		settle(2);
		chkBit(irqOut, 1'b1, "sync unmasked");
		clr();
		@(posedge clk);
		syncRun <= 1'b0;
		for (n = 0; n < 300 && extClockValid !== 1'b0; n++)
			settle(1);
		settle(2);
		chkBit(syncClockFlag & !extClockSelected, 1'b1, "disappear flag");
		for (k = 0; k < 5; k++)
		begin
			@(posedge clk);
			externalClockFreqSelect <= 5'(k);
			syncRun <= 1'b1;
			settle(60);
			chkBit(extClockValid, k == 2, "window per code");
			@(posedge clk);
			syncRun <= 1'b0;
			for (n = 0; n < 300 && extClockValid !== 1'b0; n++)
				settle(1);
		end
		clr();
		@(posedge clk);
		buckEnable <= 1'b1;
		settle(3);
		chkBit(inActive & syncClockFlag, 1'b1, "missing clock at enable");
		clr();
		@(posedge clk);
		pllEnable <= 1'b0;
		externalClockFreqSelect <= 5'h02;
		syncRun <= 1'b1;
		settle(80);
		chkBit(extClockSelected | syncClockFlag, 1'b0, "pll off keeps rc");
		@(posedge clk);
		syncRun <= 1'b0;
		$display("sync clock test done");
		for (k = 0; k < 4; k++)
		begin
			@(posedge clk);
			masterCurrent <= 9'(k + 28);
			slaveCurrent <= 9'h000;
			dualPhaseCfg <= 1'b0;
			settle(3);
			chkBit(buck0Pwm, k >= 2, "auto mode threshold");
		end
		@(posedge clk);
		dualPhaseCfg <= 1'b1;
		masterCurrent <= 9'h046;
		slaveCurrent <= 9'h032;
		settle(3);
		chkBit(secondPhaseOn, 1'b1, "phase added");
		for (n = 0; n < 12 && phaseTick0 !== 1'b1; n++)
			settle(1);
		for (n = 0; n < 12 && phaseTick1 !== 1'b1; n++)
			settle(1);
		chkVal(9'(n), 9'h005, "half period offset");
		@(posedge clk);
		masterCurrent <= 9'h00a;
		slaveCurrent <= 9'h00a;
		settle(3);
		chkBit(secondPhaseOn | buck0Pwm, 1'b0, "phase shed pfm");
		@(posedge clk);
		forceMultiphaseBit <= 1'b1;
		settle(3);
		chkBit(secondPhaseOn & buck0Pwm, 1'b1, "forced dual pwm");
		@(posedge clk);
		{masterVoutReg, slaveBuckVoltageReg, masterDelayReg, slaveBuckDelayReg} <= 32'h5aa533cc;
		{slaveDischargeEnable, slaveCurrentLimitField, slaveOtherIntEvent, slaveCurrentLimitEvent} <= 6'h37;
		@(posedge clk);
		{slaveOtherIntEvent, slaveCurrentLimitEvent} <= 2'h0;
		settle(0);
		chkBit(slaveCurrentLimitFlag & !slaveOtherIntOut, 1'b1, "slave interrupts");
		settle(2);
		chkVal({buck1VoutEff, 1'b0}, 9'h0b4, "master voltage used");
		chkVal({buck1DelayEff, slaveDischargeOut}, 9'h067, "master delay, discharge kept");
		chkVal(9'(slaveIlimOut), 9'h005, "slave limit kept");
		@(posedge clk);
		dualPhaseCfg <= 1'b0;
		settle(3);
		chkVal({buck1VoutEff, 1'b0}, 9'h14a, "slave voltage single");
		@(posedge clk);
		slaveOtherIntEvent <= 1'b1;
		@(posedge clk);
		slaveOtherIntEvent <= 1'b0;
		settle(0);
		chkBit(slaveOtherIntOut, 1'b1, "slave interrupt single");
		$display("phase test done");
		conclude();
	end
endmodule : tb_bpc_ctrl
